//--- include/dip_defs.vh
// Purpose: constants of the depth image udp packetizer
// Assumes: byte-wide image stream, one clock ref_clk at 40 MHz
// Notes:   header byte offsets are positions inside each packet
`ifndef DIP_DEFS_VH
`define DIP_DEFS_VH

// packet geometry
`define DIP_HDR_BYTES        11'd32
`define DIP_MAX_PAYLOAD      11'd1400
`define DIP_MAX_PACKET       11'd1432
`define DIP_IMG_HDR_BYTES    11'd64

// header field offsets
`define DIP_OFS_VERSION      8'h00
`define DIP_OFS_FRAME        8'h02
`define DIP_OFS_FRAGMENT     8'h04
`define DIP_OFS_LENGTH       8'h06
`define DIP_OFS_TOTAL        8'h08
`define DIP_OFS_CHECKSUM     8'h0C
`define DIP_OFS_FLAGS        8'h10
`define DIP_OFS_RESERVED     8'h14
`define DIP_OFS_DATA         8'h20

// header field values
`define DIP_VERSION          16'h0001
`define DIP_FLAGS_DEFAULT    32'h00000000
`define DIP_FLAG_IGNORE_CRC  0
`define DIP_RESERVED_FILL    96'h000000000000000000000000

// checksum
`define DIP_CRC_POLY         32'h04C11DB7
`define DIP_CRC_SEED         32'hFFFFFFFF

// default destination
`define DIP_DEST_IP          32'hE0000001
`define DIP_DEST_PORT        16'h2712

// input buffer
`define DIP_FIFO_WIDTH       8
`define DIP_FIFO_DEPTH       32

`endif

//--- logic/dip_packetizer.v
// Purpose: cut byte-wide images into numbered udp payload packets
// Assumes: source sends image size, then exactly that many bytes
// Notes:   one packet is held in a local buffer so the checksum can lead
//          img_ready drops once the 32-byte input buffer fills while no payload loads, so the
//          source sees gaps of about one packet time
`include "dip_defs.vh"
`default_nettype none

// input byte buffer with honest full and empty
module dip_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 32
) (
    input  wire             ref_clk,
    input  wire             srst,
    input  wire [WIDTH-1:0] in_data,
    input  wire             in_valid,
    output reg              in_ready,
    output wire [WIDTH-1:0] out_data,
    output reg              out_valid,
    input  wire             out_ready
);
    localparam AW = $clog2(DEPTH);

    // storage, pointers and occupancy
    reg  [WIDTH-1:0] store [0:DEPTH-1];
    reg  [AW-1:0]    wr_ptr;
    reg  [AW-1:0]    rd_ptr;
    reg  [AW:0]      fill;
    reg  [AW:0]      next_fill;
    // transfers on each side
    wire             do_wr = in_valid && in_ready;
    wire             do_rd = out_valid && out_ready;

    // head word read straight from storage
    assign out_data = store[rd_ptr];

    // occupancy after this cycle
    always @* begin
        next_fill = fill;
        if (do_wr && !do_rd) begin
            next_fill = fill + 1'b1;
        end else if (do_rd && !do_wr) begin
            next_fill = fill - 1'b1;
        end
    end

    // pointers and registered flags
    always @(posedge ref_clk) begin
        if (srst) begin
            wr_ptr    <= {AW{1'b0}};
            rd_ptr    <= {AW{1'b0}};
            fill      <= {(AW+1){1'b0}};
            in_ready  <= 1'b1;
            out_valid <= 1'b0;
        end else begin
            if (do_wr) begin
                store[wr_ptr] <= in_data;
                wr_ptr        <= wr_ptr + 1'b1;
            end
            if (do_rd) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
            fill      <= next_fill;
            in_ready  <= (next_fill != DEPTH[AW:0]);
            out_valid <= (next_fill != {(AW+1){1'b0}});
        end
    end
endmodule

module dip_packetizer (
    input  wire        ref_clk,
    input  wire        srst,
    input  wire [31:0] img_size,
    input  wire        img_size_valid,
    output reg         img_size_ready,
    input  wire [7:0]  img_data,
    input  wire        img_valid,
    output wire        img_ready,
    output reg  [7:0]  tx_data,
    output reg         tx_valid,
    output reg         tx_first,
    output reg         tx_last,
    input  wire        tx_ready,
    output reg  [31:0] dest_ip,
    output reg  [15:0] dest_port,
    output reg  [15:0] image_sequence_count
);
    localparam [3:0] ST_IDLE = 4'b0001;
    localparam [3:0] ST_HCRC = 4'b0010;
    localparam [3:0] ST_LOAD = 4'b0100;
    localparam [3:0] ST_SEND = 4'b1000;

    // reflected form of the generator, constant at elaboration
    function [31:0] rev32;
        input [31:0] v;
        integer k;
        begin
            for (k = 0; k < 32; k = k + 1) begin
                rev32[k] = v[31-k];
            end
        end
    endfunction

    localparam [31:0] POLY_REV = rev32(`DIP_CRC_POLY);

    // one byte through the crc, lsb first
    function [31:0] crc_byte;
        input [31:0] c;
        input [7:0]  d;
        integer j;
        reg [31:0] r;
        begin
            r = c;
            for (j = 0; j < 8; j = j + 1) begin
                if (r[0] ^ d[j]) begin
                    r = (r >> 1) ^ POLY_REV;
                end else begin
                    r = r >> 1;
                end
            end
            crc_byte = r;
        end
    endfunction

    // sequencer state
    reg  [3:0]  state;
    reg  [3:0]  next_state;

    // one payload held back until its checksum is known
    reg  [7:0]  pay_mem [0:1399];

    // byte position and image bookkeeping
    reg  [10:0] cnt;
    reg  [10:0] pay_len;
    reg  [31:0] remain;
    reg  [31:0] total;
    reg  [15:0] fragment_index;
    reg  [31:0] crc;
    reg  [31:0] fragment_checksum;

    // buffer side and output handshake
    wire [7:0]  buf_data;
    wire        buf_valid;
    wire        buf_take = state[2] && buf_valid;
    wire        out_free = !tx_valid || tx_ready;

    // geometry of the current fragment
    wire [10:0] pkt_end  = `DIP_HDR_BYTES + pay_len - 11'd1;
    wire [10:0] mem_idx  = cnt - `DIP_HDR_BYTES;
    wire        is_final = (remain == {21'h0, pay_len});
    wire [31:0] rem_next = remain - {21'h0, pay_len};
    wire [10:0] len_next;

    // header assembly
    wire [255:0] hdr_vec;
    wire [255:0] hdr_shift;
    wire [7:0]  hdr_byte;
    wire [7:0]  pkt_byte;

    assign len_next = (rem_next > {21'h0, `DIP_MAX_PAYLOAD}) ? `DIP_MAX_PAYLOAD
                                                             : rem_next[10:0];

    assign hdr_vec = {`DIP_VERSION, image_sequence_count, fragment_index,
                      {5'h00, pay_len}, total, fragment_checksum,
                      `DIP_FLAGS_DEFAULT, `DIP_RESERVED_FILL};

    // header byte selected by the low five bits of the index
    assign hdr_shift = hdr_vec << {cnt[4:0], 3'b000};
    assign hdr_byte  = hdr_shift[255:248];
    assign pkt_byte  = (cnt < `DIP_HDR_BYTES) ? hdr_byte : pay_mem[mem_idx];

    // input buffer, drained only while a payload loads
    dip_fifo #(
        .WIDTH (`DIP_FIFO_WIDTH),
        .DEPTH (`DIP_FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .srst      (srst),
        .in_data   (img_data),
        .in_valid  (img_valid),
        .in_ready  (img_ready),
        .out_data  (buf_data),
        .out_valid (buf_valid),
        .out_ready (state[2])
    );

    // sequencing of one packet: header crc, payload load, send
    always @* begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (img_size_valid && img_size != 32'h0) begin
                    next_state = ST_HCRC;
                end
            end
            ST_HCRC: begin
                if (cnt == `DIP_HDR_BYTES - 11'd1) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (buf_take && cnt == pay_len - 11'd1) begin
                    next_state = ST_SEND;
                end
            end
            ST_SEND: begin
                if (out_free && cnt == pkt_end) begin
                    next_state = is_final ? ST_IDLE : ST_HCRC;
                end
            end
            default: begin
                next_state = ST_IDLE;
            end
        endcase
    end

    // control registers and packet build
    always @(posedge ref_clk) begin
        if (srst) begin
            state                <= ST_IDLE;
            img_size_ready       <= 1'b1;
            cnt                  <= 11'h000;
            pay_len              <= 11'h000;
            remain               <= 32'h00000000;
            total                <= 32'h00000000;
            fragment_index       <= 16'h0000;
            crc                  <= `DIP_CRC_SEED;
            fragment_checksum    <= 32'h00000000;
            image_sequence_count <= 16'h0000;
            tx_data              <= 8'h00;
            tx_valid             <= 1'b0;
            tx_first             <= 1'b0;
            tx_last              <= 1'b0;
            dest_ip              <= `DIP_DEST_IP;
            dest_port            <= `DIP_DEST_PORT;
        end else begin
            state          <= next_state;
            img_size_ready <= (next_state == ST_IDLE);
            // an accepted byte frees the output stage
            if (out_free) begin
                tx_valid <= 1'b0;
                tx_first <= 1'b0;
                tx_last  <= 1'b0;
            end
            case (state)
                ST_IDLE: begin
                    if (next_state == ST_HCRC) begin
                        fragment_index    <= 16'h0000;
                        remain            <= img_size;
                        total             <= img_size;
                        pay_len           <= (img_size > {21'h0, `DIP_MAX_PAYLOAD})
                                             ? `DIP_MAX_PAYLOAD : img_size[10:0];
                        cnt               <= 11'h000;
                        crc               <= `DIP_CRC_SEED;
                        fragment_checksum <= 32'h00000000;
                    end
                end
                ST_HCRC: begin
                    crc <= crc_byte(crc, hdr_byte);
                    cnt <= (next_state == ST_LOAD) ? 11'h000 : cnt + 11'd1;
                end
                ST_LOAD: begin
                    if (buf_take) begin
                        pay_mem[cnt] <= buf_data;
                        crc <= crc_byte(crc, buf_data);
                        cnt <= (next_state == ST_SEND) ? 11'h000 : cnt + 11'd1;
                        if (next_state == ST_SEND) begin
                            fragment_checksum <= ~crc_byte(crc, buf_data);
                        end
                    end
                end
                ST_SEND: begin
                    if (out_free) begin
                        tx_data  <= pkt_byte;
                        tx_valid <= 1'b1;
                        tx_first <= (cnt == 11'h000);
                        tx_last  <= (cnt == pkt_end);
                        cnt      <= cnt + 11'd1;
                        // last byte: next fragment or close the image
                        if (cnt == pkt_end) begin
                            cnt <= 11'h000;
                            if (is_final) begin
                                image_sequence_count <= image_sequence_count + 16'h0001;
                            end else begin
                                fragment_index    <= fragment_index + 16'h0001;
                                remain            <= rem_next;
                                pay_len           <= len_next;
                                crc               <= `DIP_CRC_SEED;
                                fragment_checksum <= 32'h00000000;
                            end
                        end
                    end
                end
                default: begin
                    cnt <= 11'h000;
                end
            endcase
        end
    end
endmodule

`default_nettype wire

//--- test/dip_packetizer_assertions.sv
// Purpose: port checker for the packetizer
// Assumes: one clock, srst synchronous
// Notes:   idx counts bytes accepted in the packet
`default_nettype none
module dip_chk (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [31:0] img_size,
    input wire logic        img_size_valid,
    input wire logic        img_size_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_first,
    input wire logic        tx_last,
    input wire logic        tx_ready,
    input wire logic [31:0] dest_ip,
    input wire logic [15:0] dest_port,
    input wire logic [15:0] image_sequence_count
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    logic [10:0] idx;
    wire         acc = tx_valid && tx_ready;
    // byte offset inside the current packet
    always @(posedge ref_clk) begin
        if (srst || (acc && tx_last)) idx <= 11'h000;
        else if (acc) idx <= idx + 11'h001;
    end
    hold_stall_a: assert property (tx_valid && !tx_ready |=> tx_valid &&
        $stable(tx_data) && $stable(tx_last)) else $error("tx moved while stalled");
    pkt_size_a: assert property (tx_valid |-> idx <= 11'h597)
        else $error("packet longer than allowed");
    hdr_last_a: assert property (tx_valid && tx_last |-> idx >= 11'h020)
        else $error("packet ended inside header");
    version_field_a: assert property (tx_valid && idx < 11'h002 |->
        tx_data == {7'h00, idx[0]} && tx_first == (idx == 11'h000)) else $error("bad version");
    reserved_zero_a: assert property (tx_valid && idx >= 11'h010 && idx < 11'h020
        |-> tx_data == 8'h00) else $error("flags or reserved not zero");
    dest_const_a: assert property (dest_ip == 32'hE0000001 && dest_port == 16'h2712)
        else $error("destination not default");
    size_take_a: assert property (img_size_valid && img_size_ready && img_size != 32'h0
        |=> !img_size_ready ##1 !img_size_ready) else $error("size not taken");
    frame_step_a: assert property ($changed(image_sequence_count) && !$past(srst)
        |-> image_sequence_count == $past(image_sequence_count) + 16'h0001)
        else $error("frame count jumped");
    reset_idle_a: assert property (disable iff (1'b0) srst |=> img_size_ready && !tx_valid)
        else $error("not idle after reset");
    cover property (acc && tx_last && idx == 11'h597);
    cover property (tx_valid && !tx_ready);
    cover property ($changed(image_sequence_count));
endmodule
`default_nettype wire

//--- test/dip_rx_model.sv
// Purpose: network receiver taking the packet stream
// Assumes: receiver may stall at any byte
// Notes:   stall turns on random back-pressure
`default_nettype none
module dip_rx_model (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic stall,
    output var logic tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    initial tx_ready = 1'b0;
    always @(posedge ref_clk) tx_ready <= #1 !srst && (!stall || $urandom_range(3) != 0);
endmodule
`default_nettype wire

//--- test/tb_top.sv
// Purpose: self-checking bench for the packetizer
// Assumes: sizes include the image header
// Notes:   packets are rebuilt and compared field by field
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0, srst = 1'b1, img_size_valid = 1'b0, img_valid = 1'b0, stall = 1'b0;
    logic [31:0] img_size = 32'h0;
    logic [7:0]  img_data = 8'h00;
    wire         img_size_ready, img_ready, tx_valid, tx_first, tx_last, tx_ready;
    wire [7:0]   tx_data;
    wire [31:0]  dest_ip;
    wire [15:0]  dest_port, image_sequence_count;
    int          miscompares = 0, checked = 0, left = 0, frag = 0, size_q[$];
    int          sizes[6] = '{64, 1400, 1401, 2800, 2801, 0};
    logic [15:0] frame = 16'h0;
    logic [7:0]  exp_q[$], pkt[$];
    always #12.5 ref_clk = ~ref_clk;
    dip_packetizer dut (.ref_clk(ref_clk), .srst(srst), .img_size(img_size),
        .img_size_valid(img_size_valid), .img_size_ready(img_size_ready),
        .img_data(img_data), .img_valid(img_valid), .img_ready(img_ready),
        .tx_data(tx_data), .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last),
        .tx_ready(tx_ready), .dest_ip(dest_ip), .dest_port(dest_port),
        .image_sequence_count(image_sequence_count));
    dip_rx_model rx (.ref_clk(ref_clk), .srst(srst), .stall(stall), .tx_ready(tx_ready));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic stop_test();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    // reflected crc, checksum field taken as zero
    function automatic logic [31:0] crc(input logic [7:0] b[$]);
        logic [31:0] c;
        c = 32'hFFFFFFFF;
        foreach (b[i]) begin
            c = c ^ {24'h0, (i >= 12 && i < 16) ? 8'h00 : b[i]};
            repeat (8) c = c[0] ? (c >> 1) ^ 32'hEDB88320 : c >> 1;
        end
        return ~c;
    endfunction
    // big-endian field of the received packet
    function automatic logic [31:0] fld(input int o, input int n);
        fld = 32'h0;
        for (int i = 0; i < n; i++) fld = {fld[23:0], pkt[o + i]};
    endfunction
    task automatic check_pkt();
        int n, e;
        if (frag == 0) left = size_q[0];
        n = pkt.size() - 32;
        e = left > 1400 ? 1400 : left;
        chk("length", e, n);
        chk("version", 32'h1, fld(0, 2));
        chk("frame", frame, fld(2, 2));
        chk("fragment", frag, fld(4, 2));
        chk("count", n, fld(6, 2));
        chk("total", size_q[0], fld(8, 4));
        chk("checksum", crc(pkt), fld(12, 4));
        chk("flags", 32'h0, fld(16, 4));
        for (int i = 32; i < pkt.size(); i++) chk("data", exp_q.pop_front(), pkt[i]);
        left -= n;
        frag++;
        if (left <= 0) begin
            void'(size_q.pop_front());
            frame++;
            frag = 0;
        end
        pkt = {};
    endtask
    // collect accepted bytes
    always @(posedge ref_clk) if (!srst && tx_valid && tx_ready) begin
        pkt.push_back(tx_data);
        if (tx_last) check_pkt();
    end
    task automatic send_image(input int n);
        img_size = n;
        img_size_valid = 1'b1;
        do @(posedge ref_clk); while (!img_size_ready);
        size_q.push_back(n);
        #1 img_size_valid = 1'b0;
        for (int i = 0; i < n; i++) begin
            img_data = $urandom;
            img_valid = 1'b1;
            exp_q.push_back(img_data);
            do @(posedge ref_clk); while (!img_ready);
            #1;
            if ($urandom_range(7) == 0) begin
                img_valid = 1'b0;
                @(posedge ref_clk);
                #1;
            end
        end
        img_valid = 1'b0;
    endtask
    initial begin
        void'($urandom(32'hA7F53531));
        sizes[5] = $urandom_range(2000, 65);
        repeat (2) @(posedge ref_clk);
        #1 srst = 1'b0;
        chk("dest ip", 32'hE0000001, dest_ip);
        chk("dest port", 32'h2712, dest_port);
        img_size_valid = 1'b1;
        repeat (3) @(posedge ref_clk);
        #1 chk("zero size", 32'h1, img_size_ready);
        img_size_valid = 1'b0;
        @(posedge ref_clk);
        #1;
        foreach (sizes[i]) begin
            stall = i[0];
            send_image(sizes[i]);
        end
        for (int i = 0; i < 9000 && size_q.size() != 0; i++) @(posedge ref_clk);
        chk("images out", 32'h0, size_q.size());
        chk("frame count", frame, image_sequence_count);
        stop_test();
    end
    // watchdog, about two and a half times the expected run
    initial begin
        #(60000 * 25);
        miscompares++;
        stop_test();
    end
endmodule
bind dip_packetizer dip_chk chk_i (.ref_clk(ref_clk), .srst(srst), .img_size(img_size),
    .img_size_valid(img_size_valid), .img_size_ready(img_size_ready), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_first(tx_first), .tx_last(tx_last), .tx_ready(tx_ready),
    .dest_ip(dest_ip), .dest_port(dest_port), .image_sequence_count(image_sequence_count));
`default_nettype wire
